// file: bench/bcd_mul_div_unit_tb.sv
// self-checking bench for the bcd and real multiply/divide unit
`timescale 1ns/1ps
module bcd_mul_div_unit_tb;
	import bcd_mul_div_pkg::*;
	typedef struct {
		op_t op;
		src_t src;
		logic pv;
		logic [31:0] opnd, acc, expAcc, expStk;
		logic wr, push;
		logic [7:0] flg;
		int lat;
	} row_t;
	logic core_clk, nrst, opValid, ptrValid, busy, done, accWrite, stackPush;
	op_t opCode;
	src_t opSrc;
	logic [31:0] operandIn, accIn, accOut, stackData;
	logic [7:0] flags;
	int miscompares = 0;
	int nTests = 0;
	int lat;
	// flag order: zero negative badInput invalidFloat underflow badPointer signError overflow
	row_t rows[20] = '{
		'{OP_BCD_MUL16, SRC_MEM, 1, 32'h0000_5678, 32'h0000_1234, 32'h0700_6652, 0, 1, 0, 8'h00, 66},
		'{OP_BCD_MUL16, SRC_CONST, 1, 32'h0000_9999, 32'h1234_0000, 0, 0, 1, 0, 8'h80, 66},
		'{OP_BCD_MUL16, SRC_MEM, 1, 32'h0000_00A0, 32'h0000_0001, 0, 0, 0, 0, 8'hA0, 2},
		'{OP_BCD_MUL32, SRC_MEM, 1, 32'h0000_0002, 32'h1234_5678, 32'h2469_1356, 0, 1, 1, 8'h00, 66},
		'{OP_BCD_MUL32, SRC_MEM, 1, 32'h9999_9999, 32'h9999_9999, 1, 32'h9999_9998, 1, 1, 8'h00, 66},
		'{OP_BCD_DIV16, SRC_MEM, 1, 32'h0000_0003, 32'h0000_1000, 32'h0000_0333, 1, 1, 1, 8'h00, 66},
		'{OP_BCD_DIV16, SRC_MEM, 1, 32'h0000_0010, 32'h0010_0000, 0, 0, 0, 0, 8'h01, 2},
		'{OP_BCD_DIV16, SRC_MEM, 1, 32'h0000_0010, 32'h0009_9990, 32'h0000_9999, 0, 1, 1, 8'h00, 66},
		'{OP_BCD_DIV16, SRC_MEM, 1, 32'h0000_0000, 32'h0000_0005, 0, 0, 0, 0, 8'h01, 2},
		'{OP_BCD_DIV16, SRC_CONST, 1, 32'h0000_0007, 0, 0, 0, 1, 1, 8'h80, 66},
		'{OP_REAL_MUL, SRC_MEM, 1, 32'h4040_0000, 32'h4000_0000, 32'h40C0_0000, 0, 1, 0, 8'h00, 2},
		'{OP_REAL_MUL, SRC_PTR, 1, 32'h4040_0000, 32'hC000_0000, 32'hC0C0_0000, 0, 1, 0, 8'h40, 2},
		'{OP_REAL_MUL, SRC_PTR, 0, 32'h4040_0000, 32'hC000_0000, 0, 0, 0, 0, 8'h44, 2},
		'{OP_REAL_MUL, SRC_CONST, 1, 32'h3F00_0000, 32'h0080_0000, 0, 0, 1, 0, 8'h88, 2},
		'{OP_REAL_MUL, SRC_MEM, 1, 32'h4000_0000, 32'h7F00_0000, 32'h7F80_0000, 0, 1, 0, 8'h10, 2},
		'{OP_REAL_MUL, SRC_MEM, 1, 32'h3F80_0000, 32'h7FC0_0000, 0, 0, 0, 0, 8'h30, 2},
		'{OP_BCD_DIV16, SRC_MEM, 1, 32'h0000_0001, 32'h0000_00F0, 0, 0, 0, 0, 8'h30, 2},
		'{OP_BCD_MUL32, SRC_MEM, 1, 32'hA000_0000, 32'h0000_0001, 0, 0, 0, 0, 8'h30, 2},
		'{OP_BCD_MUL16, SRC_MEM, 1, 32'h0000_0003, 32'h0000_0003, 32'h0000_0009, 0, 1, 0, 8'h10, 66},
		'{OP_REAL_MUL, SRC_MEM, 0, 32'h4040_0000, 32'h4000_0000, 32'h40C0_0000, 0, 1, 0, 8'h00, 2}
	};

	bcd_mul_div_unit uut (.core_clk(core_clk), .nrst(nrst), .opValid(opValid), .opCode(opCode),
		.opSrc(opSrc), .ptrValid(ptrValid), .operandIn(operandIn), .accIn(accIn), .busy(busy),
		.done(done), .accOut(accOut), .accWrite(accWrite), .stackData(stackData),
		.stackPush(stackPush), .zeroFlag(flags[7]), .negativeFlag(flags[6]),
		.badInputFlag(flags[5]), .invalidFloatFlag(flags[4]), .underflowFlag(flags[3]),
		.badPointerFlag(flags[2]), .signErrorFlag(flags[1]), .operandOverflowFlag(flags[0]));
	seq_model seq (.core_clk(core_clk), .busy(busy), .done(done), .opValid(opValid),
		.opCode(opCode), .opSrc(opSrc), .ptrValid(ptrValid), .operandIn(operandIn),
		.accIn(accIn));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		nTests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chkIdle();
		chk("idle outputs", 32'h0000_0000, {20'h0_0000, busy, done, accWrite, stackPush, flags});
		chk("idle acc", 32'h0000_0000, accOut);
	endtask : chkIdle

	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrapUp

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// a whole pass needs about 900 cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		wrapUp();
	end

	initial begin
		nrst = 1'b0;
		repeat (10) @(posedge core_clk);
		@(negedge core_clk);
		chkIdle();
		@(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		// rows run back to back, so a held flag from an earlier row is checked too
		for (int i = 0; i < 20; i++) begin
			seq.run(rows[i].op, rows[i].src, rows[i].pv, rows[i].opnd, rows[i].acc, lat);
			chk("latency", 32'(rows[i].lat), 32'(lat));
			chk("write", 32'(rows[i].wr), 32'(accWrite));
			if (rows[i].wr) chk("acc", rows[i].expAcc, accOut);
			chk("push", 32'(rows[i].push), 32'(stackPush));
			if (rows[i].push) chk("stack", rows[i].expStk, stackData);
			chk("flags", 32'(rows[i].flg), 32'(flags));
			$display("row %0d finished", i);
		end
		// reset in the middle of a long multiply must abort it with nothing written
		fork
			seq.run(OP_BCD_MUL16, SRC_MEM, 1'b1, 32'h0000_0020, 32'h0000_0020, lat);
			begin
				repeat (20) @(posedge core_clk);
				nrst <= 1'b0;
				@(negedge core_clk);
				chkIdle();
				@(posedge core_clk);
				nrst <= 1'b1;
			end
		join
		chk("no done after reset", 32'd200, 32'(lat));
		seq.run(OP_BCD_MUL16, SRC_MEM, 1'b1, 32'h0000_0020, 32'h0000_0020, lat);
		chk("acc after reset", 32'h0000_0400, accOut);
		chk("flags after reset", 32'h0000_0000, 32'(flags));
		$display("reset test finished");
		wrapUp();
	end
endmodule : bcd_mul_div_unit_tb

// file: bench/seq_model.sv
// sequencer model: presents one operation and waits for its completion
`timescale 1ns/1ps
module seq_model
	import bcd_mul_div_pkg::*;
(
	// clock and handshake
	input wire logic core_clk,
	input wire logic busy,
	input wire logic done,
	// request
	output logic opValid,
	output op_t opCode,
	output src_t opSrc,
	output logic ptrValid,
	output logic [31:0] operandIn,
	output logic [31:0] accIn
);
	initial begin
		opValid = 1'b0;
		opCode = OP_BCD_MUL16;
		opSrc = SRC_MEM;
		ptrValid = 1'b1;
		operandIn = 32'h0000_0000;
		accIn = 32'h0000_0000;
	end

	// callers keep constants in range; released ptrValid, operandIn and accIn show the inverse, opCode and opSrc keep their values
	task automatic run(input op_t op, input src_t src, input logic pv,
		input logic [31:0] opnd, input logic [31:0] acc, output int lat);
		@(posedge core_clk);
		opValid <= 1'b1;
		opCode <= op;
		opSrc <= src;
		ptrValid <= pv;
		operandIn <= opnd;
		accIn <= acc;
		@(negedge core_clk);
		while (busy === 1'b1) begin
			@(negedge core_clk);
		end
		@(posedge core_clk);
		opValid <= 1'b0;
		ptrValid <= ~pv;
		operandIn <= ~opnd;
		accIn <= ~acc;
		lat = 0;
		do begin
			@(negedge core_clk);
			lat++;
		end while (done !== 1'b1 && lat < 200);
	endtask : run
endmodule : seq_model

// file: design/bcd_mul_div_pkg.sv
// constants, types and shared decoders for the bcd and real multiply/divide unit
package bcd_mul_div_pkg;

	typedef enum logic [3:0] {
		OP_BCD_MUL16 = 4'b0001,
		OP_BCD_MUL32 = 4'b0010,
		OP_REAL_MUL = 4'b0100,
		OP_BCD_DIV16 = 4'b1000
	} op_t;

	typedef enum logic [2:0] {
		SRC_MEM = 3'b001,
		SRC_PTR = 3'b010,
		SRC_CONST = 3'b100
	} src_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_EVAL = 4'b0010,
		S_CONV = 4'b0100,
		S_DONE = 4'b1000
	} state_t;

	localparam int CONV_CYCLES = 64;
	localparam logic [31:0] ACC_RST = 32'h0000_0000;
	localparam logic [63:0] DIV_SCALE = 64'h0000_0000_05F5_E100;
	localparam logic [26:0] QUOT_MAX = 27'h000_270F;
	localparam logic [9:0] FLOAT_BIAS = 10'h07F;
	localparam logic [7:0] EXP_ONES = 8'hFF;
	localparam logic [9:0] EXP_TOP = 10'h0FE;

	function automatic logic bcd_bad(input logic [31:0] v);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (v[i*4 +: 4] > 4'h9) begin
				bad = 1'b1;
			end
		end
		return bad;
	endfunction : bcd_bad

	function automatic logic [26:0] bcd_to_bin(input logic [31:0] v);
		logic [31:0] acc;
		acc = 32'h0000_0000;
		for (int i = 7; i >= 0; i--) begin
			acc = acc * 32'h0000_000A + {28'h000_0000, v[i*4 +: 4]};
		end
		return acc[26:0];
	endfunction : bcd_to_bin

	// double-dabble correction: add three to every digit of five or more
	function automatic logic [63:0] dabble_adj(input logic [63:0] b);
		logic [63:0] r;
		r = b;
		for (int i = 0; i < 16; i++) begin
			if (b[i*4 +: 4] > 4'h4) begin
				r[i*4 +: 4] = b[i*4 +: 4] + 4'h3;
			end
		end
		return r;
	endfunction : dabble_adj

endpackage : bcd_mul_div_pkg

// file: design/bcd_mul_div_unit.sv
// bcd and real multiply/divide datapath on the accumulator with status flags
`timescale 1ns/1ps
module bcd_mul_div_unit
	import bcd_mul_div_pkg::*;
#(
	parameter int CONV_BITS = CONV_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// operation request from the sequencer and the busy/done handshake back to it
	input wire logic opValid,
	input wire op_t opCode,
	input wire src_t opSrc,
	input wire logic ptrValid,
	input wire logic [31:0] operandIn,
	input wire logic [31:0] accIn,
	output logic busy,
	output logic done,
	// results
	output logic [31:0] accOut,
	output logic accWrite,
	output logic [31:0] stackData,
	output logic stackPush,
	// status flags
	output logic zeroFlag,
	output logic negativeFlag,
	output logic badInputFlag,
	output logic invalidFloatFlag,
	output logic underflowFlag,
	output logic badPointerFlag,
	output logic signErrorFlag,
	output logic operandOverflowFlag
);
	generate
		if (CONV_BITS != 64) begin : g_bad_conv
			$error("CONV_BITS must be 64 to cover sixteen product digits");
		end
	endgenerate

	logic [1:0] rstPipe_ff;
	logic rstSyncN;
	state_t state_ff;
	state_t nxtState;
	op_t opReg_ff;
	src_t srcReg_ff;
	logic ptrOk_ff;
	logic [31:0] accReg_ff;
	logic [31:0] operReg_ff;
	logic [63:0] bin_ff;
	logic [63:0] bcd_ff;
	logic [5:0] convCnt_ff;
	logic [31:0] accOut_ff;
	logic [31:0] stackData_ff;
	logic accWrite_ff;
	logic stackPush_ff;
	logic zero_ff;
	logic negative_ff;
	logic badInput_ff;
	logic invalidFloat_ff;
	logic underflow_ff;
	logic badPointer_ff;
	logic signError_ff;
	logic overflow_ff;
	logic accept;
	logic isReal;
	logic isDiv;
	logic ptrGood;
	logic [31:0] accUse;
	logic [31:0] operUse;
	logic bcdBad;
	logic [26:0] aBin;
	logic [26:0] bBin;
	logic [26:0] divisor;
	logic [26:0] quot;
	logic [26:0] rem;
	logic divOver;
	logic [63:0] convSrc;
	logic [63:0] adjBcd;
	logic [63:0] dabNext;
	logic finWrite;
	logic finPush;
	logic [31:0] finAcc;
	logic [31:0] finStack;

	real_mul_if rmi ();
	real_mul_core u_real_mul (
		.mi(rmi.core)
	);
	// the release is the only thing delayed; assertion of nrst acts at once
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rstPipe_ff <= 2'b00;
		end else begin
			rstPipe_ff <= {rstPipe_ff[0], 1'b1};
		end
	end
	assign rstSyncN = rstPipe_ff[1];

	assign accept = (state_ff == S_IDLE) && opValid;
	assign isReal = (opReg_ff == OP_REAL_MUL);
	assign isDiv = (opReg_ff == OP_BCD_DIV16);
	assign ptrGood = ptrOk_ff || (srcReg_ff != SRC_PTR);

	// operand capture; the sequencer may change its inputs once taken
	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			opReg_ff <= OP_BCD_MUL16;
			srcReg_ff <= SRC_MEM;
			ptrOk_ff <= 1'b1;
			accReg_ff <= ACC_RST;
			operReg_ff <= ACC_RST;
		end else if (accept) begin
			opReg_ff <= opCode;
			srcReg_ff <= opSrc;
			ptrOk_ff <= ptrValid;
			accReg_ff <= accIn;
			operReg_ff <= operandIn;
		end
	end

	// evaluation of the captured operands
	always_comb begin
		accUse = (opReg_ff == OP_BCD_MUL16) ? {16'h0000, accReg_ff[15:0]} : accReg_ff;
		operUse = (opReg_ff == OP_BCD_MUL32) ? operReg_ff : {16'h0000, operReg_ff[15:0]};
		bcdBad = bcd_bad(accUse) || bcd_bad(operUse);
		aBin = bcd_to_bin(accUse);
		bBin = bcd_to_bin(operUse);
		divisor = (bBin == 27'h000_0000) ? 27'h000_0001 : bBin;
		quot = aBin / divisor;
		rem = aBin % divisor;
		// a four-digit quotient is all the divide can return
		divOver = (bBin == 27'h000_0000) || (quot > QUOT_MAX);
		convSrc = isDiv ? 64'(quot) * DIV_SCALE + 64'(rem)
			: 64'(aBin) * 64'(bBin);
	end
	assign rmi.opA = accReg_ff;
	assign rmi.opB = operReg_ff;
	assign adjBcd = dabble_adj(bcd_ff);
	assign dabNext = {adjBcd[62:0], bin_ff[63]};
	always_comb begin
		nxtState = state_ff;
		finWrite = 1'b0;
		finPush = 1'b0;
		finAcc = accOut_ff;
		finStack = stackData_ff;
		case (state_ff)
			S_IDLE: begin
				if (opValid) begin
					nxtState = S_EVAL;
				end
			end
			S_EVAL: begin
				if (isReal) begin
					nxtState = S_DONE;
					if (ptrGood && !rmi.badIn) begin
						finWrite = 1'b1;
						finAcc = rmi.product;
					end
				end else if (bcdBad || (isDiv && divOver)) begin
					nxtState = S_DONE;
				end else begin
					nxtState = S_CONV;
				end
			end
			S_CONV: begin
				if (convCnt_ff == 6'(CONV_BITS - 1)) begin
					nxtState = S_DONE;
					finWrite = 1'b1;
					finPush = (opReg_ff != OP_BCD_MUL16);
					if (isDiv) begin
						finAcc = dabNext[63:32];
						finStack = dabNext[31:0];
					end else begin
						finAcc = dabNext[31:0];
						finStack = dabNext[63:32];
					end
				end
			end
			S_DONE: begin
				nxtState = S_IDLE;
			end
			default: begin
				nxtState = S_IDLE;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxtState;
		end
	end
	// binary to bcd, one bit a cycle
	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			bin_ff <= 64'h0000_0000_0000_0000;
			bcd_ff <= 64'h0000_0000_0000_0000;
			convCnt_ff <= 6'h00;
		end else if (state_ff == S_EVAL) begin
			bin_ff <= convSrc;
			bcd_ff <= 64'h0000_0000_0000_0000;
			convCnt_ff <= 6'h00;
		end else if (state_ff == S_CONV) begin
			bin_ff <= {bin_ff[62:0], 1'b0};
			bcd_ff <= dabNext;
			convCnt_ff <= convCnt_ff + 6'h01;
		end
	end
	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			accOut_ff <= ACC_RST;
			stackData_ff <= ACC_RST;
			accWrite_ff <= 1'b0;
			stackPush_ff <= 1'b0;
		end else begin
			accOut_ff <= finAcc;
			stackData_ff <= finStack;
			accWrite_ff <= finWrite;
			stackPush_ff <= finPush;
		end
	end
	// flags change only when an operation that owns them finishes evaluating, and zero/negative when it writes its result
	always_ff @(posedge core_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			zero_ff <= 1'b0;
			negative_ff <= 1'b0;
			badInput_ff <= 1'b0;
			invalidFloat_ff <= 1'b0;
			underflow_ff <= 1'b0;
			badPointer_ff <= 1'b0;
			signError_ff <= 1'b0;
			overflow_ff <= 1'b0;
		end else begin
			if (state_ff == S_EVAL) begin
				if (isReal) begin
					badPointer_ff <= !ptrGood;
					if (ptrGood) begin
						badInput_ff <= rmi.badIn;
					end
					if (ptrGood && !rmi.badIn) begin
						invalidFloat_ff <= (rmi.product[30:23] == EXP_ONES);
						underflow_ff <= rmi.under;
						signError_ff <= rmi.signErr;
					end
				end else begin
					badInput_ff <= bcdBad;
					if (isDiv && !bcdBad) begin
						overflow_ff <= divOver;
					end
				end
			end
			if (finWrite) begin
				zero_ff <= isReal ? (finAcc[30:0] == 31'h0000_0000) : (finAcc == ACC_RST);
				negative_ff <= finAcc[31];
			end
		end
	end

	assign busy = (state_ff != S_IDLE);
	assign done = (state_ff == S_DONE);
	assign accOut = accOut_ff;
	assign accWrite = accWrite_ff;
	assign stackData = stackData_ff;
	assign stackPush = stackPush_ff;
	assign zeroFlag = zero_ff;
	assign negativeFlag = negative_ff;
	assign badInputFlag = badInput_ff;
	assign invalidFloatFlag = invalidFloat_ff;
	assign underflowFlag = underflow_ff;
	assign badPointerFlag = badPointer_ff;
	assign signErrorFlag = signError_ff;
	assign operandOverflowFlag = overflow_ff;

	// checks
	logic inBcdBad;
	assign inBcdBad = (opCode == OP_BCD_MUL16) ?
		(bcd_bad({16'h0000, accIn[15:0]}) || bcd_bad({16'h0000, operandIn[15:0]})) :
		(opCode == OP_BCD_MUL32) ? (bcd_bad(accIn) || bcd_bad(operandIn)) :
		(bcd_bad(accIn) || bcd_bad({16'h0000, operandIn[15:0]}));

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstSyncN);
	sequence s_take_real;
		accept && opCode == OP_REAL_MUL;
	endsequence
	sequence s_abort_end;
		done && !accWrite && !stackPush;
	endsequence

	property p_zero_bcd;
		accWrite && !isReal |-> zeroFlag == (accOut == ACC_RST);
	endproperty
	a_zero_bcd: assert property (p_zero_bcd) else $error("zero flag wrong");
	property p_negative;
		accWrite |-> negativeFlag == accOut[31];
	endproperty
	a_negative: assert property (p_negative) else $error("negative flag wrong");
	property p_bad_digit;
		accept && opCode != OP_REAL_MUL && inBcdBad |-> ##2 s_abort_end ##0 badInputFlag;
	endproperty
	a_bad_digit: assert property (p_bad_digit) else $error("bad digit not caught");
	property p_zero_div;
		accept && opCode == OP_BCD_DIV16 && !inBcdBad && operandIn[15:0] == 16'h0000
			|-> ##2 s_abort_end ##0 operandOverflowFlag;
	endproperty
	a_zero_div: assert property (p_zero_div) else $error("zero divisor not refused");
	property p_bad_ptr;
		s_take_real ##0 (opSrc == SRC_PTR && !ptrValid) |-> ##2 s_abort_end ##0 badPointerFlag;
	endproperty
	a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer not flagged");
	property p_real_time;
		s_take_real |-> ##1 !done ##1 done;
	endproperty
	a_real_time: assert property (p_real_time) else $error("real multiply late");
	property p_bcd_time;
		accept && opCode != OP_REAL_MUL && !inBcdBad && opCode != OP_BCD_DIV16
			|-> ##66 (done && accWrite);
	endproperty
	a_bcd_time: assert property (p_bcd_time) else $error("bcd multiply not written");
	property p_push;
		accWrite && !isReal |-> stackPush == (opReg_ff != OP_BCD_MUL16);
	endproperty
	a_push: assert property (p_push) else $error("stack push wrong");
	property p_flag_hold;
		$changed(badInputFlag) || $changed(zeroFlag) |-> $past(state_ff) != S_IDLE;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag moved while idle");
	property p_invalid;
		accWrite && isReal |-> invalidFloatFlag == (accOut[30:23] == EXP_ONES);
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid float flag wrong");
	property p_under;
		accWrite && isReal && underflowFlag |-> accOut[30:0] == 31'h0000_0000;
	endproperty
	a_under: assert property (p_under) else $error("underflow result not zero");

endmodule : bcd_mul_div_unit

// file: design/real_mul_core.sv
// combinational single-precision multiplier with flush-to-zero and truncation
`timescale 1ns/1ps
module real_mul_core
	import bcd_mul_div_pkg::*;
(
	// operands and result
	real_mul_if.core mi
);
	logic [7:0] expA;
	logic [7:0] expB;
	logic [47:0] mant;
	logic [9:0] expSum;
	logic [22:0] frac;
	logic sgn;
	logic zeroIn;

	always_comb begin
		expA = mi.opA[30:23];
		expB = mi.opB[30:23];
		sgn = mi.opA[31] ^ mi.opB[31];
		mi.badIn = (expA == EXP_ONES) || (expB == EXP_ONES);
		// denormals count as zero; a trade for a much smaller datapath
		zeroIn = (expA == 8'h00) || (expB == 8'h00);
		mant = {24'h00_0000, 1'b1, mi.opA[22:0]} * {24'h00_0000, 1'b1, mi.opB[22:0]};
		expSum = {2'b00, expA} + {2'b00, expB} - FLOAT_BIAS;
		if (mant[47]) begin
			frac = mant[46:24];
			expSum = expSum + 10'h001;
		end else begin
			frac = mant[45:23];
		end
		mi.under = 1'b0;
		if (zeroIn) begin
			mi.product = {sgn, 31'h0000_0000};
		end else if (expSum[9] || expSum == 10'h000) begin
			mi.product = {sgn, 31'h0000_0000};
			mi.under = 1'b1;
		end else if (expSum > EXP_TOP) begin
			mi.product = {sgn, EXP_ONES, 23'h00_0000};
		end else begin
			mi.product = {sgn, expSum[7:0], frac};
		end
		mi.signErr = !mi.badIn && (mi.product[31] != sgn);
	end

endmodule : real_mul_core

// file: design/real_mul_if.sv
// operands and result between the unit and its single-precision multiplier
`timescale 1ns/1ps
interface real_mul_if;
	logic [31:0] opA;
	logic [31:0] opB;
	logic [31:0] product;
	logic badIn;
	logic under;
	logic signErr;
	modport core (input opA, input opB, output product, output badIn, output under,
		output signErr);
	modport user (output opA, output opB, input product, input badIn, input under,
		input signErr);
endinterface : real_mul_if
